// >>> design/pcu_pkg.sv
// Contract
// - Data array holds up to 800 entries.
// - Single fast input is the only trigger.
// - Software writes cannot fake a trigger.
// - Source is encoder, linear scale or pulses.
// - Source change refused while compare uses capture.
// - Position latched within 5 us of edge.
// - Fast input captures regardless of input assignment.
// - Enabling capture forces input assignment to 0x0100.
// - Forced assignment never saved; default after power-up.
// - Edge trigger with selectable contact polarity.
// - Successive edges store successive entries, no rearm.
// - Programmable hold-off interval ignores edges after capture.
// - Each capture decrements remaining count to zero.
// - Last capture clears enable, raises done output.
// - Entries stored from start index consecutively.
// - Enable with zero count disables, clears done.
package pcu_pkg;
   // Register byte offsets; 13 address bits so all 800 array words are reachable
   localparam logic [12:0] OFS_CTRL      = 13'h0000; // capture_control_word
   localparam logic [12:0] OFS_SRC       = 13'h0004; // capture_source_select
   localparam logic [12:0] OFS_COUNT     = 13'h0008; // capture_remaining_count
   localparam logic [12:0] OFS_START     = 13'h000C; // capture_start_index
   localparam logic [12:0] OFS_INTERVAL  = 13'h0010; // hold-off in cycles
   localparam logic [12:0] OFS_INFUNC    = 13'h0014; // input_function_assign
   localparam logic [12:0] OFS_STATUS    = 13'h0018; // sticky events, read clears
   localparam logic [12:0] OFS_MASK      = 13'h001C;
   localparam logic [12:0] OFS_CMPSRC    = 13'h0020; // compare uses capture axis
   localparam logic [12:0] OFS_ARRAY     = 13'h1000; // data array window base, one word per entry
   // Control word fields
   localparam int CTRL_EN    = 0;
   localparam int CTRL_POL   = 4; // 1: normally-closed contact, falling edge
   // Status fields
   localparam int ST_CAPT    = 0;
   localparam int ST_DONE    = 1;
   localparam int ST_REFUSE  = 2;
   // Sources
   localparam logic [1:0] SRC_MAIN  = 2'h0;
   localparam logic [1:0] SRC_AUX   = 2'h1;
   localparam logic [1:0] SRC_PULSE = 2'h2;
   // Values
   localparam logic [15:0] INFUNC_DEFAULT = 16'h0000; // arbitrary power-up default
   localparam logic [15:0] INFUNC_FORCED  = 16'h0100;
   localparam int ARRAY_DEPTH = 800;
   // Timing
   localparam int CLK_NS        = 10;
   localparam int LATCH_MAX_NS  = 5000;
   localparam int LATCH_MAX_CYC = LATCH_MAX_NS / CLK_NS;
endpackage

// >>> design/pcu_top.sv
`timescale 1ns/1ns
module pcu_top #(
   parameter int DEPTH = pcu_pkg::ARRAY_DEPTH
)(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [12:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [12:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Position sources
   input  wire logic [31:0] pos_main,
   input  wire logic [31:0] pos_aux,
   input  wire logic [31:0] pos_pulse,
   // Trigger pin and outputs
   input  wire logic        fast_trigger_input,
   output logic             capture_done_output,
   output logic             irq
);
   localparam int AW = $clog2(DEPTH);

   // Registers
   logic        en_ff, pol_ff, cmp_cap_ff;
   logic [1:0]  src_ff;
   logic [15:0] count_ff;
   logic [15:0] start_ff;
   logic [15:0] idx_ff;
   logic [31:0] interval_ff;
   logic [31:0] hold_ff;
   logic [15:0] infunc_ff;
   logic [2:0]  status_ff, mask_ff;
   logic [31:0] mem [DEPTH];
   logic        done_ff;

   // Bus handshake state
   logic        aw_ok_ff, w_ok_ff;
   logic [12:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        wr_go, rd_go;

   // Input synchroniser and edge detect
   logic sync1_ff, sync2_ff, prev_ff;
   logic edge_seen, accept, last_cap;

   // Two-flop synchroniser; first stage feeds only the second
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff  <= 1'b0;
      end
      else
      begin
         sync1_ff <= fast_trigger_input;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   // Rising edge for NO contact, falling for NC; no software path reaches here
   assign edge_seen = pol_ff ? (prev_ff & ~sync2_ff) : (~prev_ff & sync2_ff);
   assign accept    = edge_seen & en_ff & (count_ff != 16'h0000) & (hold_ff == 32'h0);
   assign last_cap  = accept & (count_ff == 16'h0001);

   // Latch into array; three cycles after the pin, well inside 5 us
   always_ff @(posedge aclk)
   begin
      if (accept && idx_ff < 16'(DEPTH))
         mem[idx_ff[AW-1:0]] <= (src_ff == pcu_pkg::SRC_AUX)   ? pos_aux :
                                (src_ff == pcu_pkg::SRC_PULSE) ? pos_pulse : pos_main;
   end

   // Hold-off counter, loaded on each capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hold_ff <= 32'h0;
      else if (accept)
         hold_ff <= interval_ff;
      else if (hold_ff != 32'h0)
         hold_ff <= hold_ff - 32'h1;
   end

   assign wr_go = aw_ok_ff & w_ok_ff & ~s_axi_bvalid;
   assign rd_go = s_axi_arvalid & s_axi_arready;

   // Write channels, taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ok_ff <= 1'b0;
         w_ok_ff  <= 1'b0;
         awaddr_ff <= 13'h0000;
         wdata_ff  <= 32'h0;
         wstrb_ff  <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok_ff  <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok_ff  <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_ok_ff <= 1'b0;
            w_ok_ff  <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // Registered write readies; each closes once its beat is held and reopens as the write completes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= wr_go | ~(aw_ok_ff | (s_axi_awvalid & s_axi_awready));
         s_axi_wready  <= wr_go | ~(w_ok_ff | (s_axi_wvalid & s_axi_wready));
      end
   end
   assign s_axi_bresp   = 2'b00;

   // Configuration and capture state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         en_ff <= 1'b0; pol_ff <= 1'b0; cmp_cap_ff <= 1'b0;
         src_ff <= pcu_pkg::SRC_MAIN;
         count_ff <= 16'h0; start_ff <= 16'h0; idx_ff <= 16'h0;
         interval_ff <= 32'h0; mask_ff <= 3'h0; done_ff <= 1'b0;
         infunc_ff <= pcu_pkg::INFUNC_DEFAULT;
      end
      else
      begin
         if (wr_go && wstrb_ff[0])
         begin
            unique case (awaddr_ff)
               pcu_pkg::OFS_CTRL:
               begin
                  pol_ff <= wdata_ff[pcu_pkg::CTRL_POL];
                  if (wdata_ff[pcu_pkg::CTRL_EN])
                  begin
                     done_ff <= 1'b0;
                     idx_ff  <= start_ff;
                     en_ff   <= (count_ff != 16'h0);
                     if (count_ff != 16'h0)
                        infunc_ff <= pcu_pkg::INFUNC_FORCED;
                  end
                  else
                     en_ff <= 1'b0;
               end
               pcu_pkg::OFS_SRC:
                  if (!cmp_cap_ff)
                     src_ff <= wdata_ff[1:0];
               pcu_pkg::OFS_COUNT:    count_ff <= wdata_ff[15:0];
               pcu_pkg::OFS_START:    start_ff <= wdata_ff[15:0];
               pcu_pkg::OFS_INTERVAL: interval_ff <= wdata_ff;
               pcu_pkg::OFS_INFUNC:   infunc_ff <= wdata_ff[15:0];
               pcu_pkg::OFS_MASK:     mask_ff <= wdata_ff[2:0];
               pcu_pkg::OFS_CMPSRC:   cmp_cap_ff <= wdata_ff[0];
               default: ;
            endcase
         end
         if (accept)
         begin
            count_ff <= count_ff - 16'h1;
            idx_ff   <= idx_ff + 16'h1;
            if (last_cap)
            begin
               en_ff   <= 1'b0;
               done_ff <= 1'b1;
            end
         end
      end
   end

   // Sticky status; hardware set wins over read-clear
   logic [2:0] ev;
   logic       st_rd;
   assign ev[pcu_pkg::ST_CAPT]   = accept;
   assign ev[pcu_pkg::ST_DONE]   = last_cap;
   assign ev[pcu_pkg::ST_REFUSE] = wr_go & wstrb_ff[0] & (awaddr_ff == pcu_pkg::OFS_SRC) & cmp_cap_ff;
   assign st_rd = rd_go & (s_axi_araddr == pcu_pkg::OFS_STATUS);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status_ff <= 3'h0;
         irq       <= 1'b0;
         capture_done_output <= 1'b0;
      end
      else
      begin
         status_ff <= (st_rd ? 3'h0 : status_ff) | ev;
         irq       <= |(((st_rd ? 3'h0 : status_ff) | ev) & mask_ff);
         capture_done_output <= done_ff;
      end
   end

   // Read channel: one cycle latency; unmapped reads return zero OKAY
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         if (s_axi_araddr >= pcu_pkg::OFS_ARRAY)
            s_axi_rdata <= (32'(s_axi_araddr[11:2]) < DEPTH) ? mem[s_axi_araddr[AW+1:2]] : 32'h0;
         else
            unique case (s_axi_araddr)
               pcu_pkg::OFS_CTRL:     s_axi_rdata <= {27'h0, pol_ff, 3'h0, en_ff};
               pcu_pkg::OFS_SRC:      s_axi_rdata <= {30'h0, src_ff};
               pcu_pkg::OFS_COUNT:    s_axi_rdata <= {16'h0, count_ff};
               pcu_pkg::OFS_START:    s_axi_rdata <= {16'h0, start_ff};
               pcu_pkg::OFS_INTERVAL: s_axi_rdata <= interval_ff;
               pcu_pkg::OFS_INFUNC:   s_axi_rdata <= {16'h0, infunc_ff};
               pcu_pkg::OFS_STATUS:   s_axi_rdata <= {29'h0, status_ff};
               pcu_pkg::OFS_MASK:     s_axi_rdata <= {29'h0, mask_ff};
               pcu_pkg::OFS_CMPSRC:   s_axi_rdata <= {31'h0, cmp_cap_ff};
               default:               s_axi_rdata <= 32'h0;
            endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
   // Registered address ready: reopens in the cycle after the data beat is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_arready <= 1'b0;
      else
         s_axi_arready <= ~rd_go & (~s_axi_rvalid | s_axi_rready);
   end
   assign s_axi_rresp   = 2'b00;

   // Done follows the last capture: enable drops first, the output one cycle later
   sequence s_done_rise;
      !en_ff ##1 capture_done_output;
   endsequence

   // Checks
   a_count_decr: assert property (@(posedge aclk) disable iff (!aresetn)
      accept |=> count_ff == $past(count_ff) - 16'h1) else $error("count not decremented");
   a_done_last: assert property (@(posedge aclk) disable iff (!aresetn)
      last_cap |=> s_done_rise) else $error("done not raised");
   a_holdoff: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && interval_ff > 32'h2 |=> !accept [*2]) else $error("edge in hold-off");
   a_src_lock: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_cap_ff && $past(cmp_cap_ff) |-> $stable(src_ff)) else $error("source changed");
   a_force_fn: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(en_ff) |-> infunc_ff == pcu_pkg::INFUNC_FORCED) else $error("input function not forced");
   a_idx_step: assert property (@(posedge aclk) disable iff (!aresetn)
      accept |=> idx_ff == $past(idx_ff) + 16'h1) else $error("index not advanced");
   a_zero_en: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && wstrb_ff[0] && awaddr_ff == pcu_pkg::OFS_CTRL && wdata_ff[pcu_pkg::CTRL_EN] && count_ff == 16'h0
      |=> !en_ff && !done_ff) else $error("enable at zero count not refused");
   // Selected pin edge, once past the first stage, must be seen by the next cycle
   a_edge_lat: assert property (@(posedge aclk) disable iff (!aresetn)
      (sync1_ff != sync2_ff) && (sync1_ff ^ pol_ff) |=> edge_seen || $changed(pol_ff))
      else $error("edge not seen in time");
   // Read data must stand until the master takes it
   a_rd_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_edge_one: assert property (@(posedge aclk) disable iff (!aresetn)
      accept |=> !accept) else $error("two latches per edge");
endmodule

// >>> tb/pcu_trig_model.sv
`timescale 1ns/1ns
module pcu_trig_model (
   // Clock
   input  wire logic aclk,
   // Bench request
   input  wire logic fire,
   input  wire logic pol,
   // Trigger pin
   output logic      fast_trigger_input
);
   logic [2:0] width_ff = 3'h0;

   // Pulse stands 4 cycles so a two-stage synchroniser cannot miss it
   always_ff @(posedge aclk)
   begin
      if (fire)
         width_ff <= 3'h4;
      else if (width_ff != 3'h0)
         width_ff <= width_ff - 3'h1;
   end

   // Idle level follows the contact kind, so the active edge flips with it
   assign fast_trigger_input = pol ^ (width_ff != 3'h0);
endmodule

// >>> tb/position_capture_unit_tb.sv
`timescale 1ns/1ns
module position_capture_unit_tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [12:0] awaddr = 13'h0000;
   logic [12:0] araddr = 13'h0000;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rv;
   logic [31:0] rdata;
   logic [31:0] p_main = 32'h0;
   logic [31:0] p_aux = 32'h0;
   logic [31:0] p_pulse = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        fire = 1'b0;
   logic        pol = 1'b0;
   logic        trig, done, irq, awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp, wrsp;
   int          err_count = 0;
   int          checks_done = 0;

   // 100 MHz
   always #5 aclk = ~aclk;

   pcu_top pcu_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pos_main(p_main),
      .pos_aux(p_aux), .pos_pulse(p_pulse), .fast_trigger_input(trig), .capture_done_output(done),
      .irq(irq));
   pcu_trig_model pcu_trig_model_inst (.aclk(aclk), .fire(fire), .pol(pol), .fast_trigger_input(trig));

   task stop_test;
      if (err_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   // Ready and valid are read just after the rising edge, so they hold the values sampled at it
   task wr(input logic [12:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      wrsp = bresp;
      bready <= 1'b0;
   endtask

   task rd(input logic [12:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   task rc(input string n, input logic [12:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(n, v, e);
   endtask

   function logic [31:0] ev(input logic [1:0] s, input logic [7:0] k);
      ev = 32'hA0000000 + {2'h0, s, 28'h0} + {24'h0, k};
   endfunction

   // One pin pulse; positions move away 9 cycles later, far inside the latch limit
   task cap(input logic [7:0] k);
      @(posedge aclk);
      p_main <= ev(2'h0, k);
      p_aux <= ev(2'h1, k);
      p_pulse <= ev(2'h2, k);
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (8) @(posedge aclk);
      p_main <= 32'h0;
      p_aux <= 32'h0;
      p_pulse <= 32'h0;
   endtask

   // Three captures from one source; the third of four edges falls inside the hold-off of 30 cycles
   task run(input logic [1:0] s);
      pol <= s[0];
      wr(pcu_pkg::OFS_SRC, {30'h0, s});
      rc("src", pcu_pkg::OFS_SRC, {30'h0, s});
      wr(pcu_pkg::OFS_COUNT, 32'h3);
      wr(pcu_pkg::OFS_START, 32'h5);
      wr(pcu_pkg::OFS_INTERVAL, 32'h1E);
      wr(pcu_pkg::OFS_MASK, 32'h1);
      wr(pcu_pkg::OFS_CTRL, {27'h0, s[0], 4'h1});
      rc("infunc", pcu_pkg::OFS_INFUNC, 32'h100);
      cap(8'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      repeat (30) @(posedge aclk);
      cap(8'h2);
      cap(8'h3);
      repeat (30) @(posedge aclk);
      cap(8'h4);
      chk("done", {31'h0, done}, 32'h1);
      rc("ctrl", pcu_pkg::OFS_CTRL, {27'h0, s[0], 4'h0});
      rc("count", pcu_pkg::OFS_COUNT, 32'h0);
      rc("entry5", pcu_pkg::OFS_ARRAY + 12'h014, ev(s, 8'h1));
      rc("entry6", pcu_pkg::OFS_ARRAY + 12'h018, ev(s, 8'h2));
      rc("entry7", pcu_pkg::OFS_ARRAY + 12'h01C, ev(s, 8'h4));
      rc("status", pcu_pkg::OFS_STATUS, 32'h3);
      repeat (2) @(posedge aclk);
      chk("irq", {31'h0, irq}, 32'h0);
   endtask

   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rc("infunc", pcu_pkg::OFS_INFUNC, 32'h0);
      wr(pcu_pkg::OFS_CMPSRC, 32'h1);
      wr(pcu_pkg::OFS_SRC, 32'h2);
      rc("src", pcu_pkg::OFS_SRC, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      rc("status", pcu_pkg::OFS_STATUS, 32'h4);
      wr(pcu_pkg::OFS_CMPSRC, 32'h0);
      chk("bresp", {30'h0, wrsp}, 32'h0);
      rd(13'h0040, rv);
      chk("rresp", {30'h0, rsp}, 32'h0);
      wr(pcu_pkg::OFS_INFUNC, 32'h5);
      for (int i = 0; i < 3; i++)
         run(2'(i));
      wr(pcu_pkg::OFS_COUNT, 32'h0);
      wr(pcu_pkg::OFS_CTRL, 32'h1);
      rc("ctrl", pcu_pkg::OFS_CTRL, 32'h0);
      chk("done", {31'h0, done}, 32'h0);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rc("infunc", pcu_pkg::OFS_INFUNC, 32'h0);
      stop_test();
   end

   // The whole run needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge aclk);
      err_count++;
      stop_test();
   end
endmodule
